// ===== design/gpio_port.sv
// One port: pin data, direction, interrupts, alternate-function routing and pad control.
// Assumes its bus request already decoded to this port and pins synchronised upstream.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module gpio_port #(
	parameter logic [7:0] AFSEL_INIT = 8'h00,
	parameter logic [7:0] PUR_INIT = 8'h00,
	parameter logic [31:0] PCTL_INIT = 32'h0000_0000,
	parameter logic [7:0] TRIG_PINS = 8'h00
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire gpio_pkg::bus_req_t req_in,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] periph_out_in [16],
	input wire logic [7:0] periph_oe_in [16],
	output logic [7:0] rdata_out,
	output gpio_pkg::pad_ctl_t pad_out,
	output logic [7:0] digital_in_out,
	output logic [31:0] func_code_out,
	output logic irq_out,
	output logic trig_out
);
	logic [7:0] pin_data_reg_r, pin_direction_reg_r, sense_r, both_r, event_r;
	logic [7:0] pin_interrupt_mask_reg_r, raw_r, prev_r;
	logic [7:0] alt_function_select_reg_r, digital_enable_reg_r, pull_up_select_reg_r, pull_down_select_reg_r;
	logic [31:0] port_function_control_reg_r;
	logic [7:0] din, edge_hit, level_hit, set_hit, wmask, clr, out_nxt, oe_nxt, rd_nxt;
	logic [11:0] a;
	logic trig_r;

	assign a = req_in.addr;
	assign wmask = a[gpio_pkg::MASK_LSB +: 8];
	assign din = pin_in & digital_enable_reg_r;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			pin_direction_reg_r <= 8'h00;
			sense_r <= 8'h00;
			both_r <= 8'h00;
			event_r <= 8'h00;
			pin_interrupt_mask_reg_r <= 8'h00;
			alt_function_select_reg_r <= AFSEL_INIT;
			digital_enable_reg_r <= AFSEL_INIT;
			pull_up_select_reg_r <= PUR_INIT;
			pull_down_select_reg_r <= 8'h00;
			port_function_control_reg_r <= PCTL_INIT;
		end else if (req_in.wr) begin
			case (a)
				gpio_pkg::OFF_DIR: pin_direction_reg_r <= req_in.wdata[7:0];
				gpio_pkg::OFF_SENSE: sense_r <= req_in.wdata[7:0];
				gpio_pkg::OFF_BOTH: both_r <= req_in.wdata[7:0];
				gpio_pkg::OFF_EVENT: event_r <= req_in.wdata[7:0];
				gpio_pkg::OFF_IMASK: pin_interrupt_mask_reg_r <= req_in.wdata[7:0];
				gpio_pkg::OFF_AFSEL: alt_function_select_reg_r <= req_in.wdata[7:0];
				gpio_pkg::OFF_DEN: digital_enable_reg_r <= req_in.wdata[7:0];
				gpio_pkg::OFF_PUR: pull_up_select_reg_r <= req_in.wdata[7:0];
				gpio_pkg::OFF_PDR: pull_down_select_reg_r <= req_in.wdata[7:0];
				gpio_pkg::OFF_PCTL: port_function_control_reg_r <= req_in.wdata;
				default: ;
			endcase
		end
	end

	// Input bits track the pin every cycle; output bits hold what software wrote.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			pin_data_reg_r <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (req_in.wr && a[11:10] == 2'b00 && wmask[i] && pin_direction_reg_r[i]) begin
					pin_data_reg_r[i] <= req_in.wdata[i];
				end else if (!pin_direction_reg_r[i]) begin
					pin_data_reg_r[i] <= din[i];
				end
			end
		end
	end

	// Detection: sense 1 is level, else edge with both or event polarity.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			level_hit[i] = sense_r[i] & (din[i] == event_r[i]);
			edge_hit[i] = !sense_r[i] & (both_r[i] ? (din[i] ^ prev_r[i])
				: (event_r[i] ? (din[i] & !prev_r[i]) : (!din[i] & prev_r[i])));
		end
	end
	assign set_hit = level_hit | edge_hit;
	assign clr = (req_in.wr && a == gpio_pkg::OFF_ICLR) ? req_in.wdata[7:0] : 8'h00;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			prev_r <= 8'h00;
			raw_r <= 8'h00;
			trig_r <= 1'b0;
		end else begin
			prev_r <= din;
			raw_r <= (raw_r & ~clr) | set_hit; // Set beats a clear in the same cycle.
			trig_r <= |(set_hit & pin_interrupt_mask_reg_r & TRIG_PINS);
		end
	end
	assign irq_out = |(raw_r & pin_interrupt_mask_reg_r);
	assign trig_out = trig_r;

	// Routing per pin: peripheral only when select and enable are both set; the code picks which one.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (alt_function_select_reg_r[i] && digital_enable_reg_r[i]) begin
				out_nxt[i] = periph_out_in[port_function_control_reg_r[4*i +: 4]][i];
				oe_nxt[i] = periph_oe_in[port_function_control_reg_r[4*i +: 4]][i];
			end else begin
				out_nxt[i] = pin_data_reg_r[i];
				oe_nxt[i] = pin_direction_reg_r[i] & !alt_function_select_reg_r[i];
			end
		end
	end
	assign pad_out.out = out_nxt;
	assign pad_out.oe = oe_nxt;
	assign pad_out.pull_up = pull_up_select_reg_r;
	assign pad_out.pull_down = pull_down_select_reg_r;
	assign digital_in_out = din;
	assign func_code_out = port_function_control_reg_r;

	always_comb begin
		rd_nxt = 8'h00;
		if (a[11:10] == 2'b00) begin
			rd_nxt = pin_data_reg_r & wmask;
		end else begin
			case (a)
				gpio_pkg::OFF_DIR: rd_nxt = pin_direction_reg_r;
				gpio_pkg::OFF_SENSE: rd_nxt = sense_r;
				gpio_pkg::OFF_BOTH: rd_nxt = both_r;
				gpio_pkg::OFF_EVENT: rd_nxt = event_r;
				gpio_pkg::OFF_IMASK: rd_nxt = pin_interrupt_mask_reg_r;
				gpio_pkg::OFF_RAW: rd_nxt = raw_r;
				gpio_pkg::OFF_MIS: rd_nxt = raw_r & pin_interrupt_mask_reg_r;
				gpio_pkg::OFF_AFSEL: rd_nxt = alt_function_select_reg_r;
				gpio_pkg::OFF_DEN: rd_nxt = digital_enable_reg_r;
				gpio_pkg::OFF_PUR: rd_nxt = pull_up_select_reg_r;
				gpio_pkg::OFF_PDR: rd_nxt = pull_down_select_reg_r;
				default: rd_nxt = 8'h00;
			endcase
		end
	end
	assign rdata_out = rd_nxt;

	property p_reset_defaults;
		@(posedge clock_in) !rst_n_in |=> alt_function_select_reg_r == AFSEL_INIT
			&& digital_enable_reg_r == AFSEL_INIT && pull_up_select_reg_r == PUR_INIT
			&& pull_down_select_reg_r == 8'h00 && port_function_control_reg_r == PCTL_INIT
			&& pin_direction_reg_r == 8'h00 && pin_interrupt_mask_reg_r == 8'h00;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("pin settings not at defaults after reset");

	property p_masked_write;
		@(posedge clock_in) disable iff (!rst_n_in)
			(req_in.wr && a[11:10] == 2'b00)
			|=> ((pin_data_reg_r ^ $past(pin_data_reg_r)) & $past(pin_direction_reg_r & ~wmask)) == 8'h00;
	endproperty
	a_masked_write: assert property (p_masked_write) else $error("unmasked output bit changed on data write");

	property p_input_capture;
		@(posedge clock_in) disable iff (!rst_n_in)
			1'b1 |=> ((pin_data_reg_r ^ $past(din)) & ~$past(pin_direction_reg_r)) == 8'h00;
	endproperty
	a_input_capture: assert property (p_input_capture) else $error("input bit not captured from pin");

	// A clear in the same cycle as a new event must not lose the event.
	property p_set_wins;
		@(posedge clock_in) disable iff (!rst_n_in)
			(set_hit != 8'h00) |=> (raw_r & $past(set_hit)) == $past(set_hit);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("interrupt event lost");

	property p_trig_status;
		@(posedge clock_in) disable iff (!rst_n_in) trig_out |-> (raw_r & TRIG_PINS) != 8'h00;
	endproperty
	a_trig_status: assert property (p_trig_status) else $error("trigger without status on trigger pin");
endmodule

// ===== design/gpio_pkg.sv
// Package for the five-port pin block: register offsets, reset values and carriers.
// Assumes a plain register port with byte addresses and 8-bit pin data per port.
package gpio_pkg;
	localparam int NUM_PORTS = 5;
	localparam int PIN_W = 8;
	localparam int ADDR_W = 12;
	localparam int FUNC_W = 4;

	// Offsets inside one port window; bits 11:10 of the address pick the register group.
	localparam logic [11:0] OFF_DATA_LO = 12'h000;
	localparam logic [11:0] OFF_DATA_HI = 12'h3FC;
	localparam logic [11:0] OFF_DIR = 12'h400;
	localparam logic [11:0] OFF_SENSE = 12'h404;
	localparam logic [11:0] OFF_BOTH = 12'h408;
	localparam logic [11:0] OFF_EVENT = 12'h40C;
	localparam logic [11:0] OFF_IMASK = 12'h410;
	localparam logic [11:0] OFF_RAW = 12'h414;
	localparam logic [11:0] OFF_MIS = 12'h418;
	localparam logic [11:0] OFF_ICLR = 12'h41C;
	localparam logic [11:0] OFF_AFSEL = 12'h420;
	localparam logic [11:0] OFF_PDR = 12'h514;
	localparam logic [11:0] OFF_PUR = 12'h510;
	localparam logic [11:0] OFF_DEN = 12'h51C;
	localparam logic [11:0] OFF_PCTL = 12'h52C;
	localparam int MASK_LSB = 2;

	// Port select lives in address bits 14:12.
	localparam int PORT_LSB = 12;
	localparam logic [2:0] PORT_B = 3'h1;

	localparam logic [7:0] ADC_TRIG_PIN = 8'h10;

	// Reset values per port, index 0 is port A.
	localparam logic [7:0] AFSEL_RST [NUM_PORTS] = '{8'h3F, 8'h0C, 8'h0F, 8'h00, 8'h00};
	localparam logic [7:0] PUR_RST [NUM_PORTS] = '{8'h00, 8'h00, 8'h0F, 8'h00, 8'h00};
	localparam logic [31:0] PCTL_RST [NUM_PORTS] =
		'{32'h0011_1111, 32'h0000_1100, 32'h0000_3333, 32'h0000_0000, 32'h0000_0000};

	localparam logic [3:0] TOGGLE_DIV = 4'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic [PIN_W-1:0] out;
		logic [PIN_W-1:0] oe;
		logic [PIN_W-1:0] pull_up;
		logic [PIN_W-1:0] pull_down;
	} pad_ctl_t;
endpackage

// ===== design/gpio_top.sv
// Top of the five-port pin block with register port, read pipeline and one interrupt line per port.
// Assumes pins come from pads asynchronously and peripherals run on clock_in.
//
// How it works
// - Five independent port instances, alike but for reset values and trigger pin.
// - Output pin can toggle every two cycles.
// - Edge or level interrupt detection, maskable.
// - Address bits mask data reads and writes.
// - Port logic can trigger converter sampling.
// - Digital enable cleared isolates input path.
// - Peripheral drives pin with select, enable, code.
// - Function code held per pin independently.
// - Other pins reset to tristate plain GPIO.
// - Reset returns all pin settings to defaults.
// - Serial and bus pins reset to code one.
// - Debug pins reset pulled up, code three.
// - Masked write updates only selected data bits.
// - Direction zero captures pin, one drives.
// - Unmasked trigger pin event pulses converter.
`timescale 1ns/1ns
module gpio_top (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [14:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic [7:0] pin_in [5],
	input wire logic [7:0] periph_out_in [5][16],
	input wire logic [7:0] periph_oe_in [5][16],
	output gpio_pkg::pad_ctl_t pad_out [5],
	output logic [7:0] digital_in_out [5],
	output logic [31:0] func_code_out [5],
	output logic [4:0] irq_out,
	output logic adc_trigger_out
);
	logic [7:0] sync1_r [5];
	logic [7:0] sync2_r [5];
	logic [7:0] prd [5];
	logic [4:0] trig;
	logic [31:0] rdata_r;
	logic [2:0] psel;

	assign psel = addr_in[14:12];

	// Pads are asynchronous, so two flops precede any detection logic.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			for (int p = 0; p < 5; p++) begin
				sync1_r[p] <= 8'h00;
				sync2_r[p] <= 8'h00;
			end
		end else begin
			for (int p = 0; p < 5; p++) begin
				sync1_r[p] <= pin_in[p];
				sync2_r[p] <= sync1_r[p];
			end
		end
	end

	for (genvar p = 0; p < 5; p++) begin : g_port
		gpio_pkg::bus_req_t req;
		assign req.addr = addr_in[11:0];
		assign req.wdata = wdata_in;
		assign req.wr = wr_in && psel == 3'(p);
		assign req.rd = rd_in && psel == 3'(p);
		gpio_port #(
			.AFSEL_INIT(gpio_pkg::AFSEL_RST[p]),
			.PUR_INIT(gpio_pkg::PUR_RST[p]),
			.PCTL_INIT(gpio_pkg::PCTL_RST[p]),
			.TRIG_PINS(p == 1 ? gpio_pkg::ADC_TRIG_PIN : 8'h00)
		) u_port (
			.clock_in(clock_in),
			.rst_n_in(rst_n_in),
			.req_in(req),
			.pin_in(sync2_r[p]),
			.periph_out_in(periph_out_in[p]),
			.periph_oe_in(periph_oe_in[p]),
			.rdata_out(prd[p]),
			.pad_out(pad_out[p]),
			.digital_in_out(digital_in_out[p]),
			.func_code_out(func_code_out[p]),
			.irq_out(irq_out[p]),
			.trig_out(trig[p])
		);
	end

	// Read data stand only in the cycle after the strobe, so a late sampler sees zero.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			rdata_r <= 32'h0000_0000;
		end else if (rd_in) begin
			if (psel < 3'h5) begin
				rdata_r <= {24'h00_0000, prd[psel]};
			end else begin
				rdata_r <= 32'h0000_0000;
			end
		end else begin
			rdata_r <= 32'h0000_0000;
		end
	end
	assign rdata_out = rdata_r;
	assign adc_trigger_out = |trig;

	// Only the second port owns a trigger-capable pin, so no other port may raise the converter trigger.
	property p_trig;
		@(posedge clock_in) disable iff (!rst_n_in) adc_trigger_out |-> trig == 5'h02;
	endproperty
	a_trig: assert property (p_trig) else $error("trigger raised by a port without a trigger pin");

	property p_read_mask;
		@(posedge clock_in) disable iff (!rst_n_in)
			(rd_in && addr_in[11:10] == 2'b00) |=> (rdata_out & ~{24'h00_0000, $past(addr_in[9:2])}) == 32'h0000_0000;
	endproperty
	a_read_mask: assert property (p_read_mask) else $error("masked data bit read as one");
endmodule

// ===== tb/pin_partner.sv
// Far side of the pin block: pad wires, external pin drivers and peripheral sources.
// Assumes one clock shared with the block under test.
`timescale 1ns/1ns
module pin_partner (
	input wire logic clock_in,
	input wire gpio_pkg::pad_ctl_t pad_in [5],
	input wire logic [7:0] ext_in [5],
	input wire logic [7:0] ext_en_in [5],
	output logic [7:0] pin_out [5],
	output logic [7:0] periph_out_out [5][16],
	output logic [7:0] periph_oe_out [5][16]
);
	logic [7:0] last_r [5] = '{default: 8'h00};
	// A floating pin without a pull shows the inverse of its last level, so stale values never pass.
	always_comb begin
		for (int p = 0; p < 5; p++) begin
			pin_out[p] = (pad_in[p].oe & pad_in[p].out) | (~pad_in[p].oe & ext_en_in[p] & ext_in[p])
				| (~pad_in[p].oe & ~ext_en_in[p] & (pad_in[p].pull_up | (~pad_in[p].pull_down & ~last_r[p])));
			for (int c = 0; c < 16; c++) begin
				periph_out_out[p][c] = 8'(p * 16 + c);
				periph_oe_out[p][c] = 8'hFF;
			end
		end
	end
	always_ff @(posedge clock_in) begin
		last_r <= pin_out;
	end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the five-port pin block.
// Assumes the pin partner model on the pad side and the plain register port.
`timescale 1ns/1ns
module tb;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [14:0] addr_in = 15'h0000;
	logic [31:0] wdata_in = 32'h0000_0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [31:0] rdata_out;
	logic [7:0] pin_in [5];
	logic [7:0] periph_out_in [5][16];
	logic [7:0] periph_oe_in [5][16];
	gpio_pkg::pad_ctl_t pad_out [5];
	logic [7:0] digital_in_out [5];
	logic [31:0] func_code_out [5];
	logic [4:0] irq_out;
	logic adc_trigger_out;
	logic [7:0] ext [5] = '{default: 8'h00};
	logic [7:0] ext_en [5] = '{default: 8'hFF};
	logic [31:0] q [$];
	logic rd_seen = 1'b0;
	logic [31:0] seed = 32'h0000_9B3B;
	logic [7:0] dat;
	int err_total = 0;
	int samples_checked = 0;
	int trig_n = 0;
	int cyc = 0;
	logic [31:0] af [5] = '{32'h3F, 32'h0C, 32'h0F, 32'h00, 32'h00};
	logic [31:0] pc [5] = '{32'h0011_1111, 32'h0000_1100, 32'h0000_3333, 32'h0, 32'h0};

	gpio_top i_gpio_top (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_in(pin_in), .periph_out_in(periph_out_in),
		.periph_oe_in(periph_oe_in), .pad_out(pad_out), .digital_in_out(digital_in_out),
		.func_code_out(func_code_out), .irq_out(irq_out), .adc_trigger_out(adc_trigger_out));
	pin_partner i_pin_partner (.clock_in(clock_in), .pad_in(pad_out), .ext_in(ext), .ext_en_in(ext_en),
		.pin_out(pin_in), .periph_out_out(periph_out_in), .periph_oe_out(periph_oe_in));

	always #50 clock_in = ~clock_in;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input int p, input logic [11:0] off, input logic [31:0] d);
		@(posedge clock_in);
		addr_in <= {3'(p), off};
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd(input int p, input logic [11:0] off, input logic [31:0] exp);
		q.push_back(exp);
		@(posedge clock_in);
		addr_in <= {3'(p), off};
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clock_in);
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken at that cycle's middle.
	always @(negedge clock_in) begin
		if (rd_seen) cmp(rdata_out, q.pop_front());
		rd_seen = rd_in;
	end

	always @(posedge clock_in) begin
		cyc++;
		if (adc_trigger_out === 1'b1) trig_n++;
		if (cyc == 8000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		if (q.size() != 0) err_total++;
		$display("Checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clock_in);
		rst_n_in <= 1'b1;
		for (int p = 0; p < 5; p++) begin
			rd(3'(p), gpio_pkg::OFF_AFSEL, af[p]);
			rd(3'(p), gpio_pkg::OFF_DEN, af[p]);
			rd(3'(p), gpio_pkg::OFF_PUR, (p == 2) ? 32'h0F : 32'h0);
			rd(3'(p), gpio_pkg::OFF_PDR, 32'h0);
			cmp(func_code_out[p], pc[p]);
		end
		wait_cyc(1);
		cmp(32'(pad_out[2].pull_up), 32'h0F);
		cmp(32'(pad_out[3].oe), 32'h0);
		$display("Reset values done");
		wr(3, gpio_pkg::OFF_DIR, 32'hFF);
		wr(3, gpio_pkg::OFF_DATA_HI, 32'h55);
		wr(3, 12'h098, 32'hEB);
		wait_cyc(1);
		cmp(32'(pad_out[3].out), 32'h73);
		cmp(32'(pad_out[3].oe), 32'hFF);
		rd(3, 12'h0C4, 32'h31);
		dat = 8'h73;
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			wr(3, {2'b00, seed[15:8], 2'b00}, seed);
			dat = (dat & ~seed[15:8]) | (seed[7:0] & seed[15:8]);
			rd(3, gpio_pkg::OFF_DATA_HI, 32'(dat));
		end
		wr(3, gpio_pkg::OFF_DATA_HI, 32'h73);
		wr(3, gpio_pkg::OFF_PCTL, 32'h40);
		wr(3, gpio_pkg::OFF_AFSEL, 32'h02);
		wr(3, gpio_pkg::OFF_DEN, 32'h02);
		wait_cyc(1);
		cmp(32'(pad_out[3].out), 32'h71);
		cmp(func_code_out[3], 32'h40);
		wr(3, gpio_pkg::OFF_AFSEL, 32'h00);
		wait_cyc(1);
		cmp(32'(pad_out[3].out), 32'h73);
		wr(3, gpio_pkg::OFF_DATA_HI, 32'hFF);
		wait_cyc(1);
		cmp(32'(pad_out[3].out), 32'hFF);
		wr(3, gpio_pkg::OFF_DATA_HI, 32'h00);
		wait_cyc(1);
		cmp(32'(pad_out[3].out), 32'h00);
		$display("Data and routing done");
		ext[4] <= 8'hFF;
		wait_cyc(4);
		cmp(32'(digital_in_out[4]), 32'h0);
		wr(4, gpio_pkg::OFF_DEN, 32'hFF);
		wait_cyc(4);
		cmp(32'(digital_in_out[4]), 32'hFF);
		wr(1, gpio_pkg::OFF_DEN, 32'h1C);
		wr(1, gpio_pkg::OFF_EVENT, 32'h10);
		wr(1, gpio_pkg::OFF_IMASK, 32'h10);
		wait_cyc(4);
		trig_n = 0;
		ext[1] <= 8'h10;
		for (int i = 0; i < 10 && irq_out[1] !== 1'b1; i++) wait_cyc(1);
		wait_cyc(2);
		cmp(32'(irq_out), 32'h02);
		cmp(32'(trig_n), 32'h1);
		rd(1, gpio_pkg::OFF_MIS, 32'h10);
		wr(1, gpio_pkg::OFF_ICLR, 32'h10);
		wait_cyc(1);
		cmp(32'(irq_out), 32'h0);
		wr(1, gpio_pkg::OFF_IMASK, 32'h00);
		ext[1] <= 8'h00;
		wait_cyc(4);
		ext[1] <= 8'h10;
		wait_cyc(5);
		rd(1, gpio_pkg::OFF_RAW, 32'h10);
		wait_cyc(1);
		cmp(32'(irq_out) | 32'(trig_n - 1), 32'h0);
		wr(1, gpio_pkg::OFF_SENSE, 32'h10);
		wr(1, gpio_pkg::OFF_ICLR, 32'h10);
		wr(1, gpio_pkg::OFF_IMASK, 32'h10);
		wait_cyc(2);
		rd(1, gpio_pkg::OFF_MIS, 32'h10);
		wait_cyc(1);
		cmp(32'(irq_out), 32'h02);
		$display("Interrupts done");
		@(posedge clock_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		rst_n_in <= 1'b1;
		rd(3, gpio_pkg::OFF_DIR, 32'h0);
		rd(3, gpio_pkg::OFF_DEN, 32'h0);
		rd(1, gpio_pkg::OFF_DEN, 32'h0C);
		rd(1, gpio_pkg::OFF_MIS, 32'h0);
		wait_cyc(1);
		cmp(func_code_out[3], 32'h0);
		cmp(32'(irq_out), 32'h0);
		$display("Reset return done");
		wait_cyc(2);
		print_verdict();
	end
endmodule
